/* File: rtl/fems_pkg.sv */
// Constants, carriers and decode helpers for the flash erase and memory map block
package fems_pkg;

    // ========================================================================
    // Special function register offsets and patterns
    localparam logic [7:0] ERASE_TRIGGER_OFS = 8'h94;
    localparam logic [7:0] FLASH_CONTROL_OFS = 8'hb2;
    localparam logic [7:0] PAGE_SELECT_OFS   = 8'hb7;
    localparam logic [7:0] PAT_PAGE          = 8'h55;
    localparam logic [7:0] PAT_MASS          = 8'haa;
    localparam int         MASS_ARM_BIT      = 1;
    localparam int         BUSY_BIT          = 7;
    localparam int         PAGE_LSB          = 1;
    localparam logic [7:0] PAGE_SELECT_RST   = 8'h00;
    localparam logic       MASS_ARM_RST      = 1'b0;
    localparam logic [7:0] SFR_RDATA_RST     = 8'h00;

    // ========================================================================
    // Program space
    localparam int          PAGE_AW    = 9;
    localparam logic [15:0] PROG_LAST  = 16'h7fff;
    localparam logic [15:0] RESET_PC   = 16'h0000;
    localparam logic [15:0] VEC_BASE   = 16'h0003;
    localparam logic [7:0]  ERASED     = 8'hff;

    // ========================================================================
    // Data space
    localparam logic [15:0] SRAM_LAST   = 16'h07ff;
    localparam logic [15:0] PERIPH_BASE = 16'hfc00;
    localparam int          PERIPH_AW   = 10;
    localparam logic [7:0]  UNMAPPED_RD = 8'h00;

    // ========================================================================
    // Enumerations
    typedef enum logic [2:0] {
        ER_IDLE = 3'b001,
        ER_PAGE = 3'b010,
        ER_MASS = 3'b100
    } fems_erase_t;

    typedef enum logic [2:0] {
        RG_SRAM   = 3'b001,
        RG_PERIPH = 3'b010,
        RG_NONE   = 3'b100
    } fems_region_t;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fems_sfr_req_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fems_data_req_t;

    typedef struct packed {
        logic        req;
        logic        is_const;
        logic [15:0] const_addr;
    } fems_code_req_t;

    // ========================================================================
    // Data space decode, used by the access path only; the checks compare addresses directly
    function automatic fems_region_t fems_region(input logic [15:0] a);
        if (a <= SRAM_LAST) begin
            return RG_SRAM;
        end else if (a >= PERIPH_BASE) begin
            return RG_PERIPH;
        end
        return RG_NONE;
    endfunction : fems_region

endpackage : fems_pkg

/* File: rtl/fems_mem.sv */
// Single-port memory with a registered read port
module fems_mem #(
    parameter int AW = 11,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Access
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    // ========================================================================
    // Storage
    logic [DW-1:0] mem [2**AW];

    // Array itself has no reset; contents survive a core reset
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // Registered read, cleared so the output is defined from reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[addr];
        end
    end

endmodule : fems_mem

/* File: rtl/fems_top.sv */
// Program and data address decode with a guarded flash erase sequencer
module fems_top
    import fems_pkg::*;
#(
    parameter int PROG_AW = 15,
    parameter int SRAM_AW = 11
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // Special function register port
    input  fems_sfr_req_t       sfr,
    output logic [7:0]          sfr_rdata,
    // Debug port status
    input  wire logic           debug_en,
    // Fetch pointer control
    input  wire logic           fetch_next,
    input  wire logic           jump_valid,
    input  wire logic [15:0]    jump_addr,
    input  wire logic           irq_valid,
    input  wire logic [3:0]     irq_num,
    output logic [15:0]         fetch_pc,
    // Program space reads
    input  fems_code_req_t      code,
    output logic                code_ready,
    output logic                code_valid,
    output logic [7:0]          code_rdata,
    // Data space access
    input  fems_data_req_t      data,
    output logic                data_valid,
    output logic [7:0]          data_rdata,
    // Peripheral register region
    output logic                periph_sel,
    output logic                periph_we,
    output logic [PERIPH_AW-1:0] periph_addr,
    output logic [7:0]          periph_wdata,
    input  wire logic [7:0]     periph_rdata,
    // Status
    output logic                erase_busy
);

    // ========================================================================
    // Declarations
    fems_erase_t          erase_state;
    logic [PROG_AW-1:0]   erase_addr;
    logic [7:0]           page_select;
    logic                 page_armed;
    logic                 mass_arm;
    logic                 wr_trig;
    logic                 start_page;
    logic                 start_mass;
    logic                 erase_last;
    logic [15:0]          code_addr;
    logic                 code_take;
    logic                 code_oob;
    logic                 flash_we;
    logic [PROG_AW-1:0]   flash_addr;
    logic [7:0]           flash_q;
    fems_region_t         region;
    fems_region_t         region_q;
    logic                 sram_we;
    logic [7:0]           sram_q;
    logic [7:0]           side_q;
    default clocking chk_clk @(posedge clk);
    endclocking
    default disable iff (rst);

    // Interrupt entry address for a given source number
    function automatic logic [15:0] vec_addr(input logic [3:0] n);
        return VEC_BASE + {9'h000, n, 3'b000};
    endfunction : vec_addr

    // ========================================================================
    // Register writes and arming
    assign wr_trig    = sfr.we && (sfr.addr == ERASE_TRIGGER_OFS);
    assign start_page = wr_trig && (sfr.wdata == PAT_PAGE) && page_armed
                        && (erase_state == ER_IDLE);
    assign start_mass = wr_trig && (sfr.wdata == PAT_MASS) && mass_arm && debug_en
                        && (erase_state == ER_IDLE);

    // Page number store; bit 0 kept for readback only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_select <= PAGE_SELECT_RST;
        end else if (sfr.we && sfr.addr == PAGE_SELECT_OFS) begin
            page_select <= sfr.wdata;
        end
    end

    // Page arm: one page erase per write of the page number
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_armed <= 1'b0;
        end else if (sfr.we && sfr.addr == PAGE_SELECT_OFS) begin
            page_armed <= 1'b1;
        end else if (start_page) begin
            page_armed <= 1'b0;
        end
    end

    // Mass arm bit; consumed by the erase it enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mass_arm <= MASS_ARM_RST;
        end else if (sfr.we && sfr.addr == FLASH_CONTROL_OFS) begin
            mass_arm <= sfr.wdata[MASS_ARM_BIT];
        end else if (start_mass) begin
            mass_arm <= 1'b0;
        end
    end

    // Readback; the trigger register is write-only and reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= SFR_RDATA_RST;
        end else if (sfr.re) begin
            unique case (sfr.addr)
                PAGE_SELECT_OFS: sfr_rdata <= page_select;
                FLASH_CONTROL_OFS: begin
                    sfr_rdata <= '0;
                    sfr_rdata[MASS_ARM_BIT] <= mass_arm;
                    sfr_rdata[BUSY_BIT] <= erase_busy;
                end
                default: sfr_rdata <= '0;
            endcase
        end
    end

    // ========================================================================
    // Erase sequencer: one location per clock, written to all ones
    assign erase_last = (erase_state == ER_PAGE) ? (&erase_addr[PAGE_AW-1:0])
                                                 : (&erase_addr);

    // reset returns the sequencer to idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            erase_state <= ER_IDLE;
            erase_addr  <= '0;
        end else begin
            unique case (erase_state)
                ER_IDLE: begin
                    if (start_page) begin
                        erase_state <= ER_PAGE;
                        erase_addr  <= PROG_AW'({page_select[7:PAGE_LSB],
                                                 {PAGE_AW{1'b0}}});
                    end else if (start_mass) begin
                        erase_state <= ER_MASS;
                        erase_addr  <= '0;
                    end
                end
                ER_PAGE, ER_MASS: begin
                    erase_addr <= erase_addr + 1'b1;
                    if (erase_last) begin
                        erase_state <= ER_IDLE;
                    end
                end
                default: begin
                    erase_state <= ER_IDLE;
                end
            endcase
        end
    end

    assign erase_busy = (erase_state != ER_IDLE);

    // ========================================================================
    // Fetch pointer; interrupts take priority over jumps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_pc <= RESET_PC;
        end else if (irq_valid) begin
            fetch_pc <= vec_addr(irq_num);
        end else if (jump_valid) begin
            fetch_pc <= jump_addr;
        end else if (fetch_next && code_ready) begin
            fetch_pc <= fetch_pc + 16'h0001;
        end
    end

    // ========================================================================
    // Program space read path
    // only fetch pointer or constant read address
    assign code_addr  = code.is_const ? code.const_addr : fetch_pc;
    // no reads while an erase runs
    assign code_ready = !erase_busy;
    assign code_take  = code.req && code_ready;

    // The single flash port is shared, so the erase owns it while busy
    assign flash_we   = erase_busy;
    assign flash_addr = erase_busy ? erase_addr : code_addr[PROG_AW-1:0];

    // Read answer follows one clock after the request is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_valid <= 1'b0;
            code_oob   <= 1'b0;
        end else begin
            code_valid <= code_take;
            // beyond 32KB there is no flash
            code_oob   <= code_take && (|(code_addr >> PROG_AW));
        end
    end

    assign code_rdata = code_oob ? ERASED : flash_q;

    fems_mem #(
        .AW (PROG_AW),
        .DW (8)
    ) u_flash (
        .clk   (clk),
        .rst   (rst),
        .we    (flash_we),
        .addr  (flash_addr),
        .wdata (ERASED),
        .rdata (flash_q)
    );

    // ========================================================================
    // Data space decode; no path from here into program space
    assign region       = fems_region(data.addr);
    assign sram_we      = data.req && data.we && (region == RG_SRAM);
    assign periph_sel   = data.req && (region == RG_PERIPH);
    assign periph_we    = periph_sel && data.we;
    assign periph_addr  = data.addr[PERIPH_AW-1:0];
    assign periph_wdata = data.wdata;

    fems_mem #(
        .AW (SRAM_AW),
        .DW (8)
    ) u_sram (
        .clk   (clk),
        .rst   (rst),
        .we    (sram_we),
        .addr  (data.addr[SRAM_AW-1:0]),
        .wdata (data.wdata),
        .rdata (sram_q)
    );

    // Peripheral data is captured in the request cycle; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_valid <= 1'b0;
            region_q   <= RG_NONE;
            side_q     <= UNMAPPED_RD;
        end else begin
            data_valid <= data.req && !data.we;
            region_q   <= region;
            side_q     <= (region == RG_PERIPH) ? periph_rdata : UNMAPPED_RD;
        end
    end

    assign data_rdata = (region_q == RG_SRAM) ? sram_q : side_q;

    // ========================================================================
    // Checks
    // zero after reset
    a_reset_pc_zero: assert property (
        $past(rst) |-> fetch_pc == 16'h0000) else $error("fetch pointer not zero after reset");
    a_vector_entry: assert property (
        irq_valid |=> fetch_pc == 16'h0003 + {9'h000, $past(irq_num), 3'b000})
        else $error("wrong interrupt entry address");
    a_prog_range: assert property (
        code_take && code_addr > 16'h7fff |=> code_valid && code_rdata == 8'hff)
        else $error("read above program space not all ones");
    // code answers need a taken request
    a_code_only: assert property (
        code_valid |-> $past(code.req) && !$past(erase_busy))
        else $error("code answer without a taken request");
    a_periph_map: assert property (
        data.req && data.addr >= 16'hfc00 |-> periph_sel && !sram_we)
        else $error("peripheral window not selected");
    a_page_start: assert property (
        wr_trig && sfr.wdata == 8'h55 && page_armed && erase_state == ER_IDLE
        |=> erase_state == ER_PAGE && !page_armed
            && erase_addr == PROG_AW'({$past(page_select[7:1]), 9'h000}))
        else $error("page erase did not start at page base");
    a_page_end: assert property (
        erase_state == ER_PAGE && erase_addr[8:0] == 9'h1ff |=> erase_state == ER_IDLE)
        else $error("page erase length wrong");
    a_mass_guard: assert property (
        wr_trig && sfr.wdata == 8'haa && !debug_en && erase_state == ER_IDLE
        |=> erase_state == ER_IDLE)
        else $error("mass erase without debug port");
    a_mass_start: assert property (
        wr_trig && sfr.wdata == 8'haa && mass_arm && debug_en && erase_state == ER_IDLE
        |=> erase_state == ER_MASS && erase_addr == '0 && !mass_arm ##1 erase_busy)
        else $error("mass erase did not start");
    a_other_pattern: assert property (
        wr_trig && sfr.wdata != 8'h55 && sfr.wdata != 8'haa && erase_state == ER_IDLE
        |=> erase_state == ER_IDLE)
        else $error("stray pattern started an erase");
    a_arm_needed: assert property (
        erase_state == ER_IDLE && !page_armed && !mass_arm |=> erase_state == ER_IDLE)
        else $error("erase started without arming");
    a_erase_ones: assert property (
        erase_busy |-> flash_we && !code_ready && flash_addr == erase_addr)
        else $error("flash not held during erase");

endmodule : fems_top

/* File: bench/fems_periph_model.sv */
// Peripheral register file model on the far side of the data port
module fems_periph_model (
    // Clock
    input  wire logic       clk,
    // Register access
    input  wire logic       sel,
    input  wire logic       we,
    input  wire logic [9:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // Storage
    logic [7:0] regs [0:1023];
    logic [7:0] junk;

    // Writes land at the edge that takes the request
    always @(posedge clk) begin
        if (sel && we) begin
            regs[addr] <= wdata;
        end
    end

    // Unselected reads show a changing pattern, never the last value
    always @(posedge clk) begin
        junk <= (junk === 8'h5a) ? 8'ha5 : 8'h5a;
    end

    // Read data answers in the request cycle
    assign rdata = sel ? regs[addr] : junk;
endmodule : fems_periph_model

/* File: bench/fems_top_tb.sv */
// Self-checking testbench for the flash erase sequencer and memory map
module fems_top_tb import fems_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // Signals
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    fems_sfr_req_t        sfr;
    logic [7:0]           sfr_rdata;
    logic                 debug_en, fetch_next, jump_valid, irq_valid;
    logic [15:0]          jump_addr, fetch_pc;
    logic [3:0]           irq_num;
    fems_code_req_t       code;
    logic                 code_ready, code_valid, data_valid, erase_busy;
    logic [7:0]           code_rdata, data_rdata, periph_wdata, periph_rdata;
    fems_data_req_t       data;
    logic                 periph_sel, periph_we;
    logic [PERIPH_AW-1:0] periph_addr;
    int                   n_mismatch = 0;
    int                   n_tests = 0;
    logic [7:0]           v, w;
    logic [15:0]          a;
    int                   n;

    // Clock, 10 ns period
    always #5 clk = ~clk;

    fems_top uut (
        .clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .debug_en(debug_en),
        .fetch_next(fetch_next), .jump_valid(jump_valid), .jump_addr(jump_addr),
        .irq_valid(irq_valid), .irq_num(irq_num), .fetch_pc(fetch_pc), .code(code),
        .code_ready(code_ready), .code_valid(code_valid), .code_rdata(code_rdata),
        .data(data), .data_valid(data_valid), .data_rdata(data_rdata),
        .periph_sel(periph_sel), .periph_we(periph_we), .periph_addr(periph_addr),
        .periph_wdata(periph_wdata), .periph_rdata(periph_rdata), .erase_busy(erase_busy)
    );

    fems_periph_model periph (
        .clk(clk), .sel(periph_sel), .we(periph_we), .addr(periph_addr),
        .wdata(periph_wdata), .rdata(periph_rdata)
    );

    // ========================================================================
    // Expectations and helpers
    function automatic logic [15:0] vec_addr(input logic [3:0] k);
        return 16'h0003 + {9'h000, k, 3'b000};
    endfunction : vec_addr

    function automatic int erase_len(input logic mass);
        return mass ? 32768 : 512;
    endfunction : erase_len

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        sfr = '{we: 1'b1, re: 1'b0, addr: ad, wdata: d};
        @(negedge clk);
        sfr.we = 1'b0;
    endtask : sfr_wr

    // Data is sampled a full cycle later; it holds until the next read
    task automatic sfr_rd(input logic [7:0] ad, output logic [7:0] d);
        @(negedge clk);
        sfr = '{we: 1'b0, re: 1'b1, addr: ad, wdata: 8'h00};
        @(negedge clk);
        sfr.re = 1'b0;
        @(negedge clk);
        d = sfr_rdata;
    endtask : sfr_rd

    // Counts busy cycles from the cycle after the trigger write
    task automatic busy_len(output int cnt);
        cnt = 0;
        while (erase_busy === 1'b1 && cnt < 40000) begin
            if (cnt == 0) check("code_ready", {15'h0, code_ready}, 16'h0);
            cnt++;
            @(negedge clk);
        end
    endtask : busy_len

    task automatic code_rd(input logic [15:0] ad, output logic [7:0] d);
        @(negedge clk);
        code = '{req: 1'b1, is_const: 1'b1, const_addr: ad};
        @(negedge clk);
        check("code_valid", {15'h0, code_valid}, 16'h1);
        d = code_rdata;
        code.req = 1'b0;
    endtask : code_rd

    task automatic data_acc(input logic wr, input logic [15:0] ad, input logic [7:0] wd,
                            output logic [7:0] d);
        @(negedge clk);
        data = '{req: 1'b1, we: wr, addr: ad, wdata: wd};
        @(negedge clk);
        if (!wr) check("data_valid", {15'h0, data_valid}, 16'h1);
        d = data_rdata;
        data.req = 1'b0;
    endtask : data_acc

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Hang guard sized well above the mass erase plus the other tests
    initial begin
        #(10 * 60000);
        n_mismatch++;
        print_verdict();
    end

    // ========================================================================
    // Main sequence
    initial begin
        sfr = '0; code = '0; data = '0; debug_en = 1'b0; fetch_next = 1'b0;
        jump_valid = 1'b0; jump_addr = 16'h0000; irq_valid = 1'b0; irq_num = 4'h0;
        void'($urandom(84));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        check("fetch_pc", fetch_pc, 16'h0000);
        sfr_rd(PAGE_SELECT_OFS, v);
        check("page_select", {8'h0, v}, 16'h0000);
        sfr_rd(FLASH_CONTROL_OFS, v);
        check("flash_control", {8'h0, v}, 16'h0000);
        // Above 0x7fff reads all ones even while flash is still unerased
        code_rd(16'h8000 | 16'($urandom), v);
        check("above program", {8'h0, v}, 16'h00ff);
        // Fetch path must use the pointer; const_addr would hit unerased flash
        jump_addr = 16'h8000;
        jump_valid = 1'b1;
        @(negedge clk);
        jump_valid = 1'b0;
        code = '{req: 1'b1, is_const: 1'b0, const_addr: 16'h0000};
        @(negedge clk);
        code.req = 1'b0;
        check("fetch read", {7'h0, code_valid, code_rdata}, 16'h01ff);
        $display("Reset values done");

        // Refused sequences leave the flash idle
        for (int i = 0; i < 6; i++) begin
            w = 8'($urandom);
            if (w == 8'h55 || w == 8'haa) w = 8'h00;
            sfr_wr(ERASE_TRIGGER_OFS, w);
            busy_len(n);
            check("stray pattern", 16'(n), 16'h0);
        end
        sfr_wr(ERASE_TRIGGER_OFS, 8'h55);
        busy_len(n);
        check("page unloaded", 16'(n), 16'h0);
        sfr_wr(ERASE_TRIGGER_OFS, 8'haa);
        busy_len(n);
        check("mass unarmed", 16'(n), 16'h0);
        sfr_wr(FLASH_CONTROL_OFS, 8'h02);
        sfr_wr(ERASE_TRIGGER_OFS, 8'haa);
        busy_len(n);
        check("mass no debug", 16'(n), 16'h0);
        $display("Refusals done");

        // Mass erase then every sampled byte reads erased
        debug_en = 1'b1;
        sfr_wr(FLASH_CONTROL_OFS, 8'h02);
        sfr_rd(FLASH_CONTROL_OFS, v);
        check("arm readback", {8'h0, v}, 16'h0002);
        sfr_wr(ERASE_TRIGGER_OFS, 8'haa);
        busy_len(n);
        check("mass length", 16'(n), 16'(erase_len(1'b1)));
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 16'h7fff : 16'($urandom) & PROG_LAST;
            code_rd(a, v);
            check("erased byte", {8'h0, v}, 16'h00ff);
        end
        sfr_wr(ERASE_TRIGGER_OFS, 8'haa);
        busy_len(n);
        check("mass rearm", 16'(n), 16'h0);
        $display("Mass erase done");

        // Page erase with a random page number
        w = 8'($urandom);
        sfr_wr(PAGE_SELECT_OFS, w);
        sfr_rd(PAGE_SELECT_OFS, v);
        check("page_select rw", {8'h0, v}, {8'h0, w});
        sfr_wr(ERASE_TRIGGER_OFS, 8'h55);
        busy_len(n);
        check("page length", 16'(n), 16'(erase_len(1'b0)));
        sfr_wr(ERASE_TRIGGER_OFS, 8'h55);
        busy_len(n);
        check("page reload", 16'(n), 16'h0);
        $display("Page erase done");

        // Fetch pointer: vectors, jump, increment, priority
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            irq_valid = 1'b1;
            jump_valid = 1'b1;
            jump_addr = 16'($urandom);
            irq_num = 4'(k);
            @(negedge clk);
            irq_valid = 1'b0;
            jump_valid = 1'b0;
            check("vector", fetch_pc, vec_addr(4'(k)));
        end
        a = 16'($urandom) & PROG_LAST;
        @(negedge clk);
        jump_valid = 1'b1;
        jump_addr = a;
        @(negedge clk);
        jump_valid = 1'b0;
        fetch_next = 1'b1;
        @(negedge clk);
        fetch_next = 1'b0;
        check("fetch step", fetch_pc, a + 16'h1);
        $display("Fetch pointer done");

        // Data space: SRAM, hole, peripheral region
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? SRAM_LAST : 16'($urandom) & SRAM_LAST;
            w = 8'($urandom);
            data_acc(1'b1, a, w, v);
            data_acc(1'b0, a, 8'h00, v);
            check("sram", {8'h0, v}, {8'h0, w});
        end
        data_acc(1'b0, 16'h0800, 8'h00, v);
        check("hole", {8'h0, v}, {8'h0, UNMAPPED_RD});
        a = PERIPH_BASE | (16'($urandom) & 16'h03ff);
        w = 8'($urandom);
        data_acc(1'b1, a, w, v);
        @(negedge clk);
        data = '{req: 1'b1, we: 1'b0, addr: a, wdata: 8'h00};
        #1;
        check("periph_sel", {15'h0, periph_sel}, 16'h1);
        check("periph_addr", {6'h0, periph_addr}, a & 16'h03ff);
        @(negedge clk);
        check("periph read", {8'h0, data_rdata}, {8'h0, w});
        data.req = 1'b0;
        $display("Data space done");

        // Reset in mid-run clears pointer and page number
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check("fetch_pc again", fetch_pc, 16'h0000);
        sfr_rd(PAGE_SELECT_OFS, v);
        check("page_select again", {8'h0, v}, 16'h0000);
        $display("Second reset done");
        print_verdict();
    end
endmodule : fems_top_tb
